// ==== design/prog_flag_fifo.sv ====
// Nine-bit first-in first-out buffer with empty, full and programmable level flags.
// Assumes write clock, read clock and all control pins are slow pins sampled on clock_i.
//
// What this block does
// - Takes nine-bit words from the data pins and shows read words on nine outputs.
// - Storage is 2**DEPTH_LOG2 words with separate read and write pointers.
// - Dual pin sampled during reset: high gives second write enable, low gives load.
// - Dual-enable mode stores on write edge with gate one low, gate two high, not full.
// - Flag mode stores on write edge with gate one low, load high, not full.
// - Words go to sequential locations regardless of reads.
// - Read on read edge when both read gates low and not empty.
// - Writes when full and reads when empty move no pointer and no data; their edges still refresh the flags.
// - While empty the outputs keep the last word read.
// - Empty flag low when nothing unread; updated only on read edges.
// - Full flag low when every location unread; updated only on write edges.
// - Almost-empty flag follows empty offset, updated on read edges only.
// - Almost-full flag follows full offset, updated on write edges only.
// - Reset empties the buffer, empty flag low, outputs low afterwards.
// - Outputs driven while output enable and both read gates are low, released otherwise.
// - In a cascade only the read-enabled device drives its outputs.
// - Four nine-bit offset registers hold low and high parts of both offsets.
// - Load low and gate one low writes offsets in turn, wrapping after four.
// - Raising load resumes normal work and keeps the offset sequence position.
// - Load low and both read gates low reads offsets in the same rotation.
// - Almost-empty low at n or fewer words, high at n+1 or more.
// - Almost-full low at depth minus m or more words, high when over m free.
// - Both offsets reset to seven words.
`timescale 1ns/10ps

module prog_flag_fifo #(
    parameter int DEPTH_LOG2 = fifo_pkg::DEPTH_LOG2_DEF
) (
    input  wire logic                        clock_i,
    input  wire logic                        rst_b_i,
    input  wire logic                        master_reset_n_i,
    input  wire logic                        write_clock_i,
    input  wire logic                        read_clock_i,
    input  wire logic [fifo_pkg::DATA_W-1:0] write_data_in_i,
    input  wire logic                        write_gate_primary_n_i,
    input  wire logic                        write_gate_second_or_load_i,
    input  wire logic                        read_gate_a_n_i,
    input  wire logic                        read_gate_b_n_i,
    input  wire logic                        output_enable_n_i,
    output logic      [fifo_pkg::DATA_W-1:0] read_data_out_o,
    output logic                             read_data_out_oe_o,
    output logic                             empty_indicator_n_o,
    output logic                             full_indicator_n_o,
    output logic                             almost_empty_indicator_n_o,
    output logic                             almost_full_indicator_n_o
);
    import fifo_pkg::*;

    localparam int DEPTH = 1 << DEPTH_LOG2;
    localparam int CMP_W = 2 * OFFSET_W + 1;
    localparam logic [CMP_W-1:0] DEPTH_CMP = CMP_W'(DEPTH);

    typedef struct packed {
        logic [PIN_W-1:0]                sync1;
        logic [PIN_W-1:0]                sync2;
        logic                            wclk_prev;
        logic                            rclk_prev;
        mode_t                           mode;
        logic [DEPTH_LOG2:0]             wptr;
        logic [DEPTH_LOG2:0]             rptr;
        logic                            empty_n;
        logic                            full_n;
        logic                            ae_n;
        logic                            af_n;
        logic                            oe;
        logic [DATA_W-1:0]               dout;
        logic [3:0][OFFSET_W-1:0]        offs;
        logic [1:0]                      sel;
    } state_t;

    localparam state_t STATE_RESET = '{
        mode    : MODE_DUAL,
        full_n  : 1'b1,
        af_n    : 1'b1,
        offs    : {OFFSET_HIGH_RESET, OFFSET_LOW_RESET, OFFSET_HIGH_RESET, OFFSET_LOW_RESET},
        default : '0
    };

    state_t            s;
    state_t            next_s;
    logic [DATA_W-1:0] mem [DEPTH];

    logic                  wrise;
    logic                  rrise;
    logic                  load_active;
    logic                  do_write;
    logic                  do_read;
    logic                  load_wr;
    logic                  load_rd;
    logic [DEPTH_LOG2:0]   wptr_n;
    logic [DEPTH_LOG2:0]   rptr_n;
    logic [DEPTH_LOG2:0]   count_n;
    logic [CMP_W-1:0]      count_cmp;
    logic [CMP_W-1:0]      empty_off;
    logic [CMP_W-1:0]      full_off;
    logic [DATA_W-1:0]     din;

    always_comb begin
        next_s = s;
        // Only the second stage is read by logic; the first feeds nothing else.
        next_s.sync1     = {write_data_in_i, master_reset_n_i, output_enable_n_i,
                            read_gate_b_n_i, read_gate_a_n_i, write_gate_second_or_load_i,
                            write_gate_primary_n_i, read_clock_i, write_clock_i};
        next_s.sync2     = s.sync1;
        next_s.wclk_prev = s.sync2[PIN_WCLK];
        next_s.rclk_prev = s.sync2[PIN_RCLK];

        din         = s.sync2[PIN_DATA +: DATA_W];
        wrise       = s.sync2[PIN_WCLK] & ~s.wclk_prev;
        rrise       = s.sync2[PIN_RCLK] & ~s.rclk_prev;
        load_active = (s.mode == MODE_PROG) & ~s.sync2[PIN_WRITE_GATE_SECOND_OR_LOAD];

        // The dual pin must be high in both modes: as enable two, or as load idle.
        do_write = wrise & ~s.sync2[PIN_WRITE_GATE_PRIMARY_N_N] & s.sync2[PIN_WRITE_GATE_SECOND_OR_LOAD] & s.full_n;
        do_read  = rrise & ~s.sync2[PIN_REN_A_N] & ~s.sync2[PIN_REN_B_N]
                   & s.empty_n & ~load_active;
        load_wr  = wrise & load_active & ~s.sync2[PIN_WRITE_GATE_PRIMARY_N_N];
        load_rd  = rrise & load_active & ~s.sync2[PIN_REN_A_N] & ~s.sync2[PIN_REN_B_N];

        // Pointers carry one extra bit so a full buffer differs from an empty one.
        wptr_n    = s.wptr + (DEPTH_LOG2+1)'(do_write);
        rptr_n    = s.rptr + (DEPTH_LOG2+1)'(do_read);
        count_n   = wptr_n - rptr_n;
        count_cmp = CMP_W'(count_n);
        empty_off = CMP_W'({s.offs[OFFSET_EMPTY_HIGH], s.offs[OFFSET_EMPTY_LOW]});
        full_off  = CMP_W'({s.offs[OFFSET_FULL_HIGH], s.offs[OFFSET_FULL_LOW]});

        next_s.wptr = wptr_n;
        next_s.rptr = rptr_n;

        // Each flag moves only on the edge of the port that owns it.
        if (wrise) begin
            next_s.full_n = (count_cmp != DEPTH_CMP);
            next_s.af_n   = (count_cmp + full_off < DEPTH_CMP);
        end
        if (rrise) begin
            next_s.empty_n = (count_n != '0);
            next_s.ae_n    = (count_cmp > empty_off);
        end

        if (do_read) begin
            next_s.dout = mem[s.rptr[DEPTH_LOG2-1:0]];
        end

        // One sequence position serves loads and reads; a clash lets the write win.
        if (load_wr) begin
            next_s.offs[s.sel] = din;
            next_s.sel         = s.sel + 2'h1;
        end else if (load_rd) begin
            next_s.dout = DATA_W'(s.offs[s.sel]);
            next_s.sel  = s.sel + 2'h1;
        end

        next_s.oe = ~s.sync2[PIN_OE_N] & ~s.sync2[PIN_REN_A_N] & ~s.sync2[PIN_REN_B_N];

        if (!s.sync2[PIN_MRST_N]) begin
            next_s.mode    = s.sync2[PIN_WRITE_GATE_SECOND_OR_LOAD] ? MODE_DUAL : MODE_PROG;
            next_s.wptr    = '0;
            next_s.rptr    = '0;
            next_s.empty_n = 1'b0;
            next_s.full_n  = 1'b1;
            next_s.ae_n    = 1'b0;
            next_s.af_n    = 1'b1;
            next_s.dout    = '0;
            next_s.offs    = STATE_RESET.offs;
            next_s.sel     = OFFSET_EMPTY_LOW;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    // The array carries no reset; the pointers alone decide what is valid.
    always_ff @(posedge clock_i) begin
        if (do_write && s.sync2[PIN_MRST_N]) begin
            mem[s.wptr[DEPTH_LOG2-1:0]] <= din;
        end
    end

    assign read_data_out_o            = s.dout;
    assign read_data_out_oe_o         = s.oe;
    assign empty_indicator_n_o        = s.empty_n;
    assign full_indicator_n_o         = s.full_n;
    assign almost_empty_indicator_n_o = s.ae_n;
    assign almost_full_indicator_n_o  = s.af_n;

    // Fill level as the checks below see it; the extra pointer bit keeps full apart from empty.
    logic [DEPTH_LOG2:0] fill_now;
    assign fill_now = s.wptr - s.rptr;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i || !s.sync2[PIN_MRST_N]);

    sequence wr_edge;
        s.sync2[PIN_WCLK] && !s.wclk_prev;
    endsequence

    sequence rd_edge;
        s.sync2[PIN_RCLK] && !s.rclk_prev;
    endsequence

    sequence dual_write;
        wr_edge ##0 (s.mode == MODE_DUAL && !s.sync2[PIN_WRITE_GATE_PRIMARY_N_N]
                     && s.sync2[PIN_WRITE_GATE_SECOND_OR_LOAD] && s.full_n);
    endsequence

    // A write that the gates and the full flag allow, in either mode.
    sequence any_write;
        wr_edge ##0 (!s.sync2[PIN_WRITE_GATE_PRIMARY_N_N] && s.sync2[PIN_WRITE_GATE_SECOND_OR_LOAD] && s.full_n);
    endsequence

    sequence prog_write;
        any_write ##0 (s.mode == MODE_PROG);
    endsequence

    // The device reset pin has just been seen high again, so the reset values must stand.
    sequence reset_exit;
        $rose(s.sync2[PIN_MRST_N]);
    endsequence

    // Refused transfers leave the pointers and the output word alone.
    chk_full_blocks_write: assert property (
        wr_edge ##0 !s.full_n |=> $stable(s.wptr))
        else $error("write pointer moved while full");

    chk_empty_blocks_read: assert property (
        rd_edge ##0 (!s.empty_n && !load_active) |=> $stable(s.rptr) && $stable(s.dout))
        else $error("read while empty changed state");

    chk_dual_write_step: assert property (
        dual_write |=> s.wptr == $past(s.wptr) + 1'b1)
        else $error("dual-enable write did not advance");

    chk_read_step: assert property (
        rd_edge ##0 (s.empty_n && !load_active && !s.sync2[PIN_REN_A_N] && !s.sync2[PIN_REN_B_N])
        |=> s.rptr == $past(s.rptr) + 1'b1)
        else $error("valid read did not advance");

    chk_empty_flag_edge: assert property (
        !rrise |=> $stable(s.empty_n))
        else $error("empty flag moved without read edge");

    chk_full_flag_edge: assert property (
        !wrise |=> $stable(s.full_n) && $stable(s.af_n))
        else $error("write-side flag moved without write edge");

    chk_almost_empty_level: assert property (
        rd_edge |=> s.ae_n == (CMP_W'(fill_now) > $past(empty_off)))
        else $error("almost-empty flag wrong");

    chk_load_rotation: assert property (
        wr_edge ##0 (load_active && !s.sync2[PIN_WRITE_GATE_PRIMARY_N_N])
        |=> s.sel == $past(s.sel) + 2'h1 && s.offs[$past(s.sel)] == $past(din))
        else $error("offset load out of sequence");

    // The reset pin is synchronised, so these look in the first cycle that the second stage shows it high.
    chk_reset_empties: assert property (
        reset_exit |-> !s.empty_n && !s.ae_n && s.full_n && s.af_n
                       && s.wptr == '0 && s.rptr == '0 && s.dout == '0)
        else $error("device reset did not empty the buffer");

    chk_mode_latch: assert property (
        reset_exit |-> s.mode == ($past(s.sync2[PIN_WRITE_GATE_SECOND_OR_LOAD]) ? MODE_DUAL : MODE_PROG))
        else $error("mode not taken from dual pin");

    chk_offset_defaults: assert property (
        reset_exit |-> empty_off == CMP_W'({OFFSET_HIGH_RESET, OFFSET_LOW_RESET})
                       && full_off == CMP_W'({OFFSET_HIGH_RESET, OFFSET_LOW_RESET})
                       && s.sel == OFFSET_EMPTY_LOW)
        else $error("offsets not at their reset values");

    // Flag levels are judged against the fill after the edge and the offsets before it.
    chk_full_flag_level: assert property (
        wr_edge |=> s.full_n == (CMP_W'(fill_now) != DEPTH_CMP))
        else $error("full flag wrong");

    chk_almost_full_level: assert property (
        wr_edge |=> s.af_n == (CMP_W'(fill_now) + $past(full_off) < DEPTH_CMP))
        else $error("almost-full flag wrong");

    chk_empty_flag_level: assert property (
        rd_edge |=> s.empty_n == (fill_now != '0))
        else $error("empty flag wrong");

    // Writes in either mode must land at the current write address before the pointer moves on.
    chk_prog_write_step: assert property (
        prog_write |=> s.wptr == $past(s.wptr) + 1'b1)
        else $error("flag-mode write did not advance");

    chk_write_stored: assert property (
        any_write |=> mem[$past(s.wptr[DEPTH_LOG2-1:0])] == $past(din))
        else $error("written word not stored in sequence");

    // A fill past the depth would mean the extra pointer bit wrapped wrongly.
    chk_fill_bound: assert property (
        CMP_W'(fill_now) <= DEPTH_CMP)
        else $error("fill level beyond depth");

    // Nothing may move a pointer, the output word or the offsets without its own strobe.
    chk_wptr_idle: assert property (
        !do_write |=> $stable(s.wptr))
        else $error("write pointer moved without a write");

    chk_rptr_idle: assert property (
        !do_read |=> $stable(s.rptr))
        else $error("read pointer moved without a read");

    chk_dout_idle: assert property (
        !do_read && !load_rd |=> $stable(s.dout))
        else $error("output word moved without a read");

    // While load is low the buffer itself stands still; only the offset path is live.
    chk_load_blocks_fifo: assert property (
        load_active |=> $stable(s.wptr) && $stable(s.rptr))
        else $error("buffer moved during offset access");

    chk_offsets_idle: assert property (
        !load_wr |=> $stable(s.offs))
        else $error("offset register changed without a load");

    chk_sel_idle: assert property (
        !load_wr && !load_rd |=> $stable(s.sel))
        else $error("offset position moved without an access");

    chk_offset_readback: assert property (
        load_rd && !load_wr |=> s.dout == $past(s.offs[s.sel]) && s.sel == $past(s.sel) + 2'h1)
        else $error("offset read out of sequence");

    // The enable is registered, so it follows the synchronised pins by one cycle.
    chk_output_enable: assert property (
        s.oe == $past(!s.sync2[PIN_OE_N] && !s.sync2[PIN_REN_A_N] && !s.sync2[PIN_REN_B_N]))
        else $error("output enable does not follow its pins");

endmodule // prog_flag_fifo

// ==== design/fifo_pkg.sv ====
// Constants shared by the nine-bit buffer with programmable level flags.
// Assumes every pin reaches the core as an ordinary input on clock_i.
package fifo_pkg;

    localparam int DATA_W         = 9;
    localparam int OFFSET_W       = 9;
    localparam int DEPTH_LOG2_DEF = 14;
    localparam int SYNC_STAGES    = 2;

    // Offset registers in their rotating load order.
    localparam logic [1:0] OFFSET_EMPTY_LOW  = 2'h0;
    localparam logic [1:0] OFFSET_EMPTY_HIGH = 2'h1;
    localparam logic [1:0] OFFSET_FULL_LOW   = 2'h2;
    localparam logic [1:0] OFFSET_FULL_HIGH  = 2'h3;

    // Both offsets come out of reset at seven words.
    localparam logic [8:0] OFFSET_LOW_RESET  = 9'h007;
    localparam logic [8:0] OFFSET_HIGH_RESET = 9'h000;

    // Bit positions in the synchronised pin vector.
    localparam int PIN_WCLK    = 0;
    localparam int PIN_RCLK    = 1;
    localparam int PIN_WRITE_GATE_PRIMARY_N_N  = 2;
    localparam int PIN_WRITE_GATE_SECOND_OR_LOAD = 3;
    localparam int PIN_REN_A_N = 4;
    localparam int PIN_REN_B_N = 5;
    localparam int PIN_OE_N    = 6;
    localparam int PIN_MRST_N  = 7;
    localparam int PIN_DATA    = 8;
    localparam int PIN_W       = PIN_DATA + DATA_W;

    // Clock period of the core in nanoseconds; the bench hard-codes a matching 20 ns half period.
    localparam int CLOCK_PERIOD_NS = 40;

    typedef enum logic {
        MODE_DUAL = 1'b0,
        MODE_PROG = 1'b1
    } mode_t;

endpackage

// ==== verif/fifo_host_model.sv ====
// Host logic that drives the pin side of the nine-bit buffer.
// Assumes the core clock is handed in and every pin changes just after its rising edge.
`timescale 1ns/10ps

module fifo_host_model (
    input  wire logic       clock_i,
    output logic            mrst_n_o,
    output logic            wclk_o,
    output logic            rclk_o,
    output logic [8:0]      wdata_o,
    output logic            wgate1_n_o,
    output logic            wgate2_o,
    output logic            rgate_a_n_o,
    output logic            rgate_b_n_o
);
    initial begin
        {mrst_n_o, wclk_o, rclk_o, wgate1_n_o, wgate2_o, rgate_a_n_o, rgate_b_n_o} = 7'h49;
        wdata_o = 9'h000;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    // No transfer is attempted while the device reset pin is low.
    task automatic mreset(input logic dual);
        mrst_n_o <= 1'b0;
        wgate2_o <= dual;
        hold(5);
        mrst_n_o <= 1'b1;
        hold(4);
        wgate2_o <= 1'b1;
        hold(2);
    endtask

    // Only one port clock pulses per call, so offset writes and reads never overlap.
    task automatic pulse(input logic wr, input logic [8:0] d, input logic g1_n, input logic g2,
                         input logic ra_n, input logic rb_n);
        wdata_o <= d;
        wgate1_n_o <= g1_n;
        wgate2_o <= g2;
        rgate_a_n_o <= ra_n;
        rgate_b_n_o <= rb_n;
        hold(3);
        if (wr) wclk_o <= 1'b1;
        else rclk_o <= 1'b1;
        hold(3);
        {wclk_o, rclk_o, wgate1_n_o, wgate2_o, rgate_a_n_o, rgate_b_n_o} <= 6'h0F;
        // Released data is inverted so a stale value cannot pass for a fresh one.
        wdata_o <= ~d;
        hold(3);
    endtask
endmodule // fifo_host_model

// ==== verif/test_dual_clock_fifo_with_prog_flags.sv ====
// Self-checking bench for the nine-bit buffer with programmable level flags.
// Assumes the host model drives the port pins but output enable, which the bench drives; depth is cut to sixteen words.
`timescale 1ns/10ps

module test_dual_clock_fifo_with_prog_flags;
    import fifo_pkg::*;
    logic       clock_i = 1'b0;
    logic       rst_b_i = 1'b0;
    logic       oe_n    = 1'b1;
    logic       mrst_n, wclk, rclk, g1_n, g2, ra_n, rb_n, oe, e_n, f_n, ae_n, af_n;
    logic [8:0] wd, dout;
    logic [8:0] offv [4] = '{9'h003, 9'h000, 9'h002, 9'h000};
    int         checks = 0;
    int         miscompares = 0;

    initial forever #20 clock_i = ~clock_i;

    fifo_host_model host_u (.clock_i(clock_i), .mrst_n_o(mrst_n), .wclk_o(wclk), .rclk_o(rclk),
        .wdata_o(wd), .wgate1_n_o(g1_n), .wgate2_o(g2), .rgate_a_n_o(ra_n), .rgate_b_n_o(rb_n));

    prog_flag_fifo #(.DEPTH_LOG2(4)) dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .master_reset_n_i(mrst_n), .write_clock_i(wclk), .read_clock_i(rclk),
        .write_data_in_i(wd), .write_gate_primary_n_i(g1_n), .write_gate_second_or_load_i(g2),
        .read_gate_a_n_i(ra_n), .read_gate_b_n_i(rb_n), .output_enable_n_i(oe_n),
        .read_data_out_o(dout), .read_data_out_oe_o(oe), .empty_indicator_n_o(e_n),
        .full_indicator_n_o(f_n), .almost_empty_indicator_n_o(ae_n), .almost_full_indicator_n_o(af_n));

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [8:0] val(input int i);
        return 9'(i * 37 + 5);
    endfunction

    task automatic wr(input logic [8:0] d);
        host_u.pulse(1'b1, d, 1'b0, 1'b1, 1'b1, 1'b1);
    endtask
    task automatic rd;
        host_u.pulse(1'b0, 9'h000, 1'b1, 1'b1, 1'b0, 1'b0);
    endtask
    task automatic owr(input logic [8:0] d);
        host_u.pulse(1'b1, d, 1'b0, 1'b0, 1'b1, 1'b1);
    endtask
    task automatic ord;
        host_u.pulse(1'b0, 9'h000, 1'b1, 1'b0, 1'b0, 1'b0);
    endtask

    // Fills with cnt words, optionally one refused extra, then drains and checks every flag.
    task automatic run(input int cnt, input int n, input int m, input logic extra);
        for (int i = 0; i < cnt; i++) begin
            wr(val(i));
            check(af_n, (i + 1) < 16 - m);
            check(f_n, (i + 1) < 16);
            check(e_n, 1'b0);
        end
        if (extra) wr(9'h155);
        // The empty flag moves only on a read edge, so one refused read lets it see the writes.
        rd();
        check(e_n, 1'b1);
        check(ae_n, cnt > n);
        for (int i = 0; i < cnt; i++) begin
            oe_n <= i[0];
            fork
                rd();
                begin
                    repeat (5) @(posedge clock_i);
                    check(oe, !i[0]);
                end
            join
            check(dout, val(i));
            check(e_n, i < cnt - 1);
            check(ae_n, cnt - 1 - i > n);
            check(f_n, cnt < 16);
            check(af_n, cnt < 16 - m);
        end
        rd();
        check(dout, val(cnt - 1));
    endtask

    task automatic end_sim;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clock_i);
        rst_b_i <= 1'b1;
        host_u.mreset(1'b1);
        check({e_n, f_n, ae_n, af_n}, 4'h5);
        check(dout, 9'h000);
        rd();
        check(dout, 9'h000);
        owr(9'h1AA);
        rd();
        check(e_n, 1'b0);
        run(16, 7, 7, 1'b1);
        host_u.mreset(1'b0);
        check(dout, 9'h000);
        for (int k = 0; k < 4; k++) owr(offv[k]);
        for (int k = 0; k < 4; k++) begin
            ord();
            check(dout, offv[k]);
        end
        offv[0] = 9'h004;
        owr(9'h004);
        for (int k = 1; k < 5; k++) begin
            ord();
            check(dout, offv[k % 4]);
        end
        run(14, 4, 2, 1'b0);
        end_sim();
    end

    initial begin
        repeat (6000) @(posedge clock_i);
        miscompares++;
        end_sim();
    end
endmodule // test_dual_clock_fifo_with_prog_flags
